// ### verif/iil_host.sv
`timescale 1ns/1ps
`include "iil_defs.svh"
module iil_host (
   input  wire logic        clk,
   input  wire logic        ack,
   input  wire logic [31:0] rdat,
   input  wire logic        drive,
   input  wire logic        oe_n,
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic [7:0]       adr,
   output logic [3:0]       sel,
   output logic [31:0]      wd,
   output logic             line,
   output logic             hung
);
   logic [31:0] rdata;
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      wd = 32'h00000000;
      hung = 1'b0;
   end
   // pull-up wins whenever the device lets go
   assign line = oe_n ? 1'b1 : drive;
   ////////////////////////////////////////
   task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {2'b00, a, 2'b00};
      sel <= 4'h1;
      wd <= {24'h000000, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 64);
      hung <= (ack !== 1'b1);
      rdata = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // edge-triggered hosts only see a new edge after a full mask
   task automatic service(input logic [7:0] old);
      xfer(1'b1, `IIL_ADR_MASK, 8'hFF);
      xfer(1'b1, `IIL_ADR_MASK, old);
   endtask
endmodule

// ### verif/iil_top_assertions.sv
`timescale 1ns/1ps
module iil_top_checker (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        serial_data_clock,
   input wire logic [4:0]  direct_cause,
   input wire logic        monitor_tx_marker,
   input wire logic        monitor_rx_marker,
   input wire logic        irq_out,
   input wire logic        irq_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////
   ack_in_one_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   read_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper read bits set");
   hole_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[5:2] == 4'hF |-> wb_dat_o == 32'h00000000)
      else $error("unmapped read not zero");
   line_drive_a: assert property (irq_out == 1'b0)
      else $error("line driven high");
   // five lows flush the two-flop synchroniser, so no rise can be pending
   line_timing_a: assert property (!serial_data_clock [*5] |=> $stable(irq_oe_n))
      else $error("request moved without clock rise");
   status_clear_a: assert property (
      wb_ack_o && !wb_we_i && wb_adr_i[5:2] == 4'h0 && direct_cause == 5'h00 && $past(direct_cause) == 5'h00
      ##1 (!wb_ack_o && direct_cause == 5'h00) [*2]
      ##1 (wb_ack_o && !wb_we_i && wb_adr_i[5:2] == 4'h0)
      |-> wb_dat_o[7:3] == 5'h00)
      else $error("status survived read");
   marker_fall_a: assert property ($fell(monitor_rx_marker) |-> !$past(monitor_tx_marker))
      else $error("marker fell unprompted");
endmodule
bind iil_top iil_top_checker iil_top_checker_inst (
   .clk               (clk),
   .reset_n           (reset_n),
   .wb_cyc_i          (wb_cyc_i),
   .wb_stb_i          (wb_stb_i),
   .wb_we_i           (wb_we_i),
   .wb_adr_i          (wb_adr_i),
   .wb_dat_o          (wb_dat_o),
   .wb_ack_o          (wb_ack_o),
   .serial_data_clock (serial_data_clock),
   .direct_cause      (direct_cause),
   .monitor_tx_marker (monitor_tx_marker),
   .monitor_rx_marker (monitor_rx_marker),
   .irq_out           (irq_out),
   .irq_oe_n          (irq_oe_n)
);

// ### verif/iil_top_bench.sv
`timescale 1ns/1ps
`include "iil_defs.svh"
module iil_top_bench;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [3:0]  sc = 4'h0;
   logic [4:0]  dc = 5'h00;
   logic [7:0]  ec = 8'h00;
   logic [7:0]  mb = 8'h00;
   logic [7:0]  ev;
   logic [11:0] cd = 12'h000;
   logic [2:0]  cv = 3'h0;
   logic [3:0]  mp = 4'h0;
   logic        txm = 1'b1;
   logic        cyc, stb, we, ack, irq, oe_n, rxm, line, hung;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wd, rd;
   logic [16:0] lfsr = 17'h13842;
   logic [3:0]  rst_idx [6] = '{`IIL_ADR_MASK, `IIL_ADR_SQX, `IIL_ADR_MODE, `IIL_ADR_MOCTL, `IIL_ADR_STATUS, 4'hF};
   int          mismatches = 0;
   int          n_compared = 0;
   int          pend;
   int          q[$];
   always #2 clk = ~clk;
   always @(posedge clk) sc <= sc + 4'h1;
   always @(posedge clk) begin
      if (hung === 1'b1) begin
         mismatches++;
         complete_run();
      end
   end
   ////////////////////////////////////////
   iil_top iil_top_inst (
      .clk               (clk),
      .reset_n           (reset_n),
      .wb_cyc_i          (cyc),
      .wb_stb_i          (stb),
      .wb_we_i           (we),
      .wb_adr_i          (adr),
      .wb_sel_i          (sel),
      .wb_dat_i          (wd),
      .wb_dat_o          (rd),
      .wb_ack_o          (ack),
      .serial_data_clock (sc[3]),
      .direct_cause      (dc),
      .ext_cause         (ec),
      .sq_code_in        (cd[3:0]),
      .ch0_code_in       (cd[7:4]),
      .ch1_code_in       (cd[11:8]),
      .code_valid        (cv),
      .mon_byte_valid    (mp[0]),
      .mon_byte_in       (mb),
      .monitor_tx_marker (txm),
      .mon_end           (mp[1]),
      .mon_acked         (mp[2]),
      .mon_aborted       (mp[3]),
      .monitor_rx_marker (rxm),
      .irq_in            (line),
      .irq_out           (irq),
      .irq_oe_n          (oe_n)
   );
   iil_host iil_host_inst (
      .clk   (clk),
      .ack   (ack),
      .rdat  (rd),
      .drive (irq),
      .oe_n  (oe_n),
      .cyc   (cyc),
      .stb   (stb),
      .we    (we),
      .adr   (adr),
      .sel   (sel),
      .wd    (wd),
      .line  (line),
      .hung  (hung)
   );
   ////////////////////////////////////////
   function automatic logic [16:0] step(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end
      else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [3:0] a, input logic [7:0] e);
      iil_host_inst.xfer(1'b0, a, 8'h00);
      n_compared++;
      if (iil_host_inst.rdata !== {24'h000000, e}) begin
         mismatches++;
         $display("wrong value reg%0d exp %h got %h", a, e, iil_host_inst.rdata);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      iil_host_inst.xfer(1'b1, a, d);
   endtask
   task automatic pulse(input logic [4:0] d, input logic [7:0] e, input logic [2:0] v, input logic [3:0] m);
      @(posedge clk);
      dc <= d;
      ec <= e;
      cv <= v;
      mp <= m;
      @(posedge clk);
      dc <= 5'h00;
      ec <= 8'h00;
      cv <= 3'h0;
      mp <= 4'h0;
   endtask
   // line only moves on a data clock rise, so allow several of them
   task automatic wfor(input int s, input logic v);
      int n;
      n = 0;
      while ((s ? rxm : line) !== v && n < 80) begin
         @(posedge clk);
         n++;
      end
      n_compared++;
      if ((s ? rxm : line) !== v) begin
         mismatches++;
         $display("wrong value pin%0d exp %b got %b", s, v, s ? rxm : line);
         complete_run();
      end
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      wr(4'hF, 8'hFF);
      foreach (rst_idx[i]) chk(rst_idx[i], 8'h00);
      wfor(0, 1'b1);
      wfor(1, 1'b1);
      $display("reset test end");
      lfsr = step(lfsr);
      pend = {lfsr[4:1], 1'b1, 3'h0};
      pulse(pend[7:3], 8'h00, 3'h0, 4'h0);
      wfor(0, 1'b0);
      chk(`IIL_ADR_STATUS, pend[7:0]);
      chk(`IIL_ADR_STATUS, 8'h00);
      wfor(0, 1'b1);
      $display("direct test end");
      wr(`IIL_ADR_MASK, 8'hF8);
      chk(`IIL_ADR_MASK, 8'hF8);
      pulse(pend[7:3], 8'h00, 3'h0, 4'h0);
      repeat (40) @(posedge clk);
      wfor(0, 1'b1);
      chk(`IIL_ADR_STATUS, 8'h00);
      iil_host_inst.service(8'h00);
      wfor(0, 1'b0);
      chk(`IIL_ADR_STATUS, pend[7:0]);
      $display("mask test end");
      wr(`IIL_ADR_MASK, 8'h01);
      lfsr = step(lfsr);
      ev = lfsr[7:0] | 8'h01;
      pulse(5'h00, ev, 3'h0, 4'h0);
      repeat (40) @(posedge clk);
      wfor(0, 1'b1);
      chk(`IIL_ADR_STATUS, 8'h01);
      chk(`IIL_ADR_STATUS, 8'h01);
      chk(`IIL_ADR_EXT, ev);
      chk(`IIL_ADR_STATUS, 8'h00);
      wr(`IIL_ADR_MASK, 8'h00);
      lfsr = step(lfsr);
      mb <= lfsr[7:0];
      pulse(5'h00, 8'h00, 3'h0, 4'h1);
      chk(`IIL_ADR_STATUS, 8'h02);
      chk(`IIL_ADR_STATUS, 8'h00);
      chk(`IIL_ADR_MODATA, mb);
      $display("extended test end");
      q = '{4'h3, 4'h5, 4'h9};
      foreach (q[i]) begin
         cd[7:4] <= q[i][3:0];
         pulse(5'h00, 8'h00, 3'h2, 4'h0);
      end
      wfor(0, 1'b0);
      chk(`IIL_ADR_STATUS, 8'h04);
      chk(`IIL_ADR_STATUS, 8'h04);
      chk(`IIL_ADR_CH0, {4'h2, q[0][3:0]});
      chk(`IIL_ADR_CH0, {4'h2, q[2][3:0]});
      chk(`IIL_ADR_CH0, {4'h0, q[2][3:0]});
      wfor(0, 1'b1);
      cd <= 12'hA96;
      pulse(5'h00, 8'h00, 3'h5, 4'h0);
      repeat (40) @(posedge clk);
      chk(`IIL_ADR_STATUS, 8'h00);
      wr(`IIL_ADR_SQX, 8'h03);
      chk(`IIL_ADR_STATUS, 8'h04);
      chk(`IIL_ADR_CH0, 8'h59);
      chk(`IIL_ADR_SQ, 8'h06);
      chk(`IIL_ADR_CH1, 8'h0A);
      cd <= 12'h596;
      pulse(5'h00, 8'h00, 3'h4, 4'h0);
      chk(`IIL_ADR_STATUS, 8'h00);
      wr(`IIL_ADR_MODE, 8'h03);
      chk(`IIL_ADR_STATUS, 8'h04);
      chk(`IIL_ADR_CH0, 8'h19);
      $display("code test end");
      pulse(5'h00, 8'h00, 3'h0, 4'h1);
      chk(`IIL_ADR_MOSTAT, 8'h00);
      wr(`IIL_ADR_MOCTL, 8'h03);
      lfsr = step(lfsr);
      mb <= lfsr[7:0];
      txm <= 1'b0;
      wfor(1, 1'b0);
      chk(`IIL_ADR_MOSTAT, 8'h01);
      chk(`IIL_ADR_MODATA, mb);
      txm <= 1'b1;
      wfor(1, 1'b1);
      wr(`IIL_ADR_MOCTL, 8'h01);
      lfsr = step(lfsr);
      mb <= lfsr[7:0];
      pulse(5'h00, 8'h00, 3'h0, 4'h2);
      pulse(5'h00, 8'h00, 3'h0, 4'h1);
      chk(`IIL_ADR_MOSTAT, 8'h03);
      pulse(5'h00, 8'h00, 3'h0, 4'h1);
      chk(`IIL_ADR_MOSTAT, 8'h00);
      chk(`IIL_ADR_MODATA, mb);
      wr(`IIL_ADR_MOCTL, 8'h04);
      pulse(5'h00, 8'h00, 3'h0, 4'hC);
      chk(`IIL_ADR_STATUS, 8'h02);
      chk(`IIL_ADR_MOSTAT, 8'h0C);
      chk(`IIL_ADR_MOSTAT, 8'h00);
      $display("monitor test end");
      complete_run();
   end
endmodule

// ### verilog/iil_defs.svh
// Summary of operation
// - five direct causes, bit 0 summarises eight extended
// - primary read clears all but two summaries, three in gen2
// - code summary cleared via channel-0 code read
// - extended read clears it and its summary
// - output released once no unmasked status bit is set
// - masked causes hidden, kept pending until unmasked
// - summaries still set when masked, no request
// - code summary from sq, ch0; ch1 gen2 terminal
// - disabled sq/ch1 flags hide changes until enabled
// - channel-0 code read clears all change flags
// - new code waits for read, reinterrupts if pending
// - code registers two deep: first then latest
// - monitor logic gen2 only, one channel non-terminal
// - ack and abort share one transmit enable
// - rx enable gates; no handshake: first byte only
// - handshake: store marker-fall bytes, drive rx marker
// - gen1: monitor byte raises monitor status directly
// - level request held while any unmasked cause remains
// - output switches on data clock rising edge
// - request line open drain, pulled low active
`ifndef IIL_DEFS_SVH
`define IIL_DEFS_SVH
// word indices on the bus, byte address = index * 4
`define IIL_ADR_STATUS  4'h0
`define IIL_ADR_MASK    4'h1
`define IIL_ADR_EXT     4'h2
`define IIL_ADR_CH0     4'h3
`define IIL_ADR_CH1     4'h4
`define IIL_ADR_SQ      4'h5
`define IIL_ADR_SQX     4'h6
`define IIL_ADR_MODE    4'h7
`define IIL_ADR_MOCTL   4'h8
`define IIL_ADR_MOSTAT  4'h9
`define IIL_ADR_MODATA  4'hA
// primary status bit positions
`define IIL_ST_EXT      0
`define IIL_ST_MON      1
`define IIL_ST_CODE     2
`define IIL_SUMMARY_MSK 8'h05
// sq transmit register enables
`define IIL_SQX_SQ_EN   0
`define IIL_SQX_CH1_EN  1
// mode register
`define IIL_MODE_GEN2   0
`define IIL_MODE_TERM   1
// monitor control and state bits
`define IIL_MOC_RX_EN   0
`define IIL_MOC_HS      1
`define IIL_MOC_TX_EN   2
`define IIL_MST_DR      0
`define IIL_MST_ER      1
`define IIL_MST_DA      2
`define IIL_MST_AB      3
// reset values
`define IIL_RST_MASK    8'h00
`define IIL_RST_SQX     8'h00
`define IIL_RST_MODE    8'h00
`define IIL_RST_MOCTL   8'h00
`endif

// ### verilog/iil_pkg.sv
package iil_pkg;
   typedef logic [7:0] iil_byte_type;
   typedef logic [3:0] iil_code_type;
   typedef enum logic [1:0] {
      IIL_CH_SQ  = 2'b00,
      IIL_CH_CH0 = 2'b01,
      IIL_CH_CH1 = 2'b10
   } iil_chan_type;
endpackage

// ### verilog/iil_top.sv
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "iil_defs.svh"
module iil_top
   import iil_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [7:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic      [31:0]  wb_dat_o,
   output logic              wb_ack_o,
   input  wire logic         serial_data_clock,
   input  wire logic [4:0]   direct_cause,
   input  wire logic [7:0]   ext_cause,
   input  wire iil_code_type sq_code_in,
   input  wire iil_code_type ch0_code_in,
   input  wire iil_code_type ch1_code_in,
   input  wire logic [2:0]   code_valid,
   input  wire logic         mon_byte_valid,
   input  wire iil_byte_type mon_byte_in,
   input  wire logic         monitor_tx_marker,
   input  wire logic         mon_end,
   input  wire logic         mon_acked,
   input  wire logic         mon_aborted,
   output logic              monitor_rx_marker,
   input  wire logic         irq_in,
   output logic              irq_out,
   output logic              irq_oe_n
);

////////////////////////////////////////////////////////////////////////////////
   logic         req;
   logic         rd;
   logic         wr;
   logic [3:0]   widx;
   iil_byte_type mask;
   iil_byte_type sq_transmit_reg;
   iil_byte_type mode;
   iil_byte_type monitor_control_reg;
   logic [3:0]   monitor_state_reg;
   iil_byte_type mon_data;
   iil_byte_type extended_status_reg;
   iil_byte_type pend;
   iil_byte_type status_word;
   iil_byte_type next_rdata;
   logic         gen2;
   logic         term;
   logic         sdc_meta;
   logic         sdc_sync;
   logic         sdc_prev;
   logic         marker_prev;
   logic         in_packet;
   logic         extended_summary_flag;
   logic         code_change_summary;
   logic         mon_summary;
   logic         rd_ch0;
   logic         sq_change_flag;
   logic         ch0_change_flag;
   logic         ch1_change_flag;
   iil_code_type code_in   [3];
   iil_code_type code_last [3];
   iil_code_type code_cur  [3];
   iil_code_type code_pend [3];
   logic [2:0]   pend_v;
   logic [2:0]   unread;
   logic [2:0]   flag;
   logic [2:0]   is_new;
   logic [2:0]   rd_own;
   logic [2:0]   load;
   logic         rx_take;
   logic         marker_fall;

   function automatic logic hit(input logic [3:0] idx, input logic [3:0] want);
      hit = idx == want;
   endfunction

////////////////////////////////////////////////////////////////////////////////
// bus slave: ack one cycle after the request, effects at that edge
   assign widx = wb_adr_i[5:2];
   assign rd   = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
   assign wr   = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
   assign gen2 = mode[`IIL_MODE_GEN2];
   assign term = mode[`IIL_MODE_TERM];
   assign rd_ch0 = rd & hit(widx, `IIL_ADR_CH0);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_dat_o <= 32'h00000000;
      end else if (rd) begin
         wb_dat_o <= {24'h000000, next_rdata};
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mask                <= `IIL_RST_MASK;
         sq_transmit_reg     <= `IIL_RST_SQX;
         mode                <= `IIL_RST_MODE;
         monitor_control_reg <= `IIL_RST_MOCTL;
      end else if (wr) begin
         if (hit(widx, `IIL_ADR_MASK)) begin
            mask <= wb_dat_i[7:0];
         end
         if (hit(widx, `IIL_ADR_SQX)) begin
            sq_transmit_reg <= wb_dat_i[7:0];
         end
         if (hit(widx, `IIL_ADR_MODE)) begin
            mode <= wb_dat_i[7:0];
         end
         if (hit(widx, `IIL_ADR_MOCTL)) begin
            monitor_control_reg <= wb_dat_i[7:0];
         end
      end
   end

   // masked direct causes and monitor summary read as zero, extended and code summaries always shown
   always_comb begin
      next_rdata = 8'h00;
      case (widx)
         `IIL_ADR_STATUS: next_rdata = status_word & (~mask | `IIL_SUMMARY_MSK);
         `IIL_ADR_MASK:   next_rdata = mask;
         `IIL_ADR_EXT:    next_rdata = extended_status_reg;
         `IIL_ADR_CH0:    next_rdata = {1'b0, sq_change_flag, ch0_change_flag, ch1_change_flag, code_cur[1]};
         `IIL_ADR_CH1:    next_rdata = {4'h0, code_cur[2]};
         `IIL_ADR_SQ:     next_rdata = {4'h0, code_cur[0]};
         `IIL_ADR_SQX:    next_rdata = sq_transmit_reg;
         `IIL_ADR_MODE:   next_rdata = mode;
         `IIL_ADR_MOCTL:  next_rdata = monitor_control_reg;
         `IIL_ADR_MOSTAT: next_rdata = {4'h0, monitor_state_reg};
         `IIL_ADR_MODATA: next_rdata = mon_data;
         default:         next_rdata = 8'h00;
      endcase
   end

////////////////////////////////////////////////////////////////////////////////
// primary and extended status
   assign extended_summary_flag = |extended_status_reg;
   assign mon_summary = gen2 ? |monitor_state_reg : pend[`IIL_ST_MON];
   assign status_word = {pend[7:3], code_change_summary, mon_summary, extended_summary_flag};
   // summaries set regardless of mask but never request when masked
   assign req = |(status_word & ~mask);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         extended_status_reg <= 8'h00;
      end else begin
         // a cause in the read cycle survives the clear
         extended_status_reg <= (extended_status_reg & ~{8{rd & hit(widx, `IIL_ADR_EXT)}}) | ext_cause;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pend <= 8'h00;
      end else begin
         if (rd & hit(widx, `IIL_ADR_STATUS)) begin
            // masked bits stay pending, extended and code summaries untouched
            pend[7:3] <= (pend[7:3] & mask[7:3]) | direct_cause;
            pend[`IIL_ST_MON] <= (pend[`IIL_ST_MON] & mask[`IIL_ST_MON])
                                 | (~gen2 & mon_byte_valid);
         end else begin
            pend[7:3] <= pend[7:3] | direct_cause;
            pend[`IIL_ST_MON] <= pend[`IIL_ST_MON] | (~gen2 & mon_byte_valid);
         end
         pend[`IIL_ST_EXT]  <= 1'b0;
         pend[`IIL_ST_CODE] <= 1'b0;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// code change channels, each with one waiting slot
   assign code_in[0] = sq_code_in;
   assign code_in[1] = ch0_code_in;
   assign code_in[2] = ch1_code_in;

   always_comb begin
      rd_own[0] = rd & hit(widx, `IIL_ADR_SQ);
      rd_own[1] = rd_ch0;
      rd_own[2] = rd & hit(widx, `IIL_ADR_CH1);
      for (int i = 0; i < 3; i++) begin
         is_new[i] = code_valid[i] & (code_in[i] != code_last[i]);
         // unread contents block a load; the read frees the slot
         load[i]   = (rd_own[i] & pend_v[i]) | (is_new[i] & (rd_own[i] | ~unread[i]));
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 3; i++) begin
            code_last[i] <= 4'h0;
            code_cur[i]  <= 4'h0;
            code_pend[i] <= 4'h0;
         end
         pend_v <= 3'b000;
         unread <= 3'b000;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (code_valid[i]) begin
               code_last[i] <= code_in[i];
            end
            if (rd_own[i] & pend_v[i]) begin
               code_cur[i] <= code_pend[i];
               unread[i]   <= 1'b1;
               pend_v[i]   <= is_new[i];
               if (is_new[i]) begin
                  code_pend[i] <= code_in[i];
               end
            end else if (load[i]) begin
               code_cur[i] <= code_in[i];
               unread[i]   <= 1'b1;
            end else if (is_new[i]) begin
               // later changes overwrite the slot, latest code wins
               code_pend[i] <= code_in[i];
               pend_v[i]    <= 1'b1;
            end else if (rd_own[i]) begin
               unread[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flag <= 3'b000;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (load[i]) begin
               flag[i] <= 1'b1;
            end else if (rd_ch0) begin
               flag[i] <= 1'b0;
            end
         end
      end
   end

   // disabled flags stay stored and appear once re-enabled
   assign sq_change_flag  = flag[0] & sq_transmit_reg[`IIL_SQX_SQ_EN];
   assign ch0_change_flag = flag[1];
   assign ch1_change_flag = flag[2] & sq_transmit_reg[`IIL_SQX_CH1_EN];
   assign code_change_summary = sq_change_flag | ch0_change_flag
                                | (ch1_change_flag & gen2 & term);

////////////////////////////////////////////////////////////////////////////////
// monitor channel, control and state gen2 only, gen1 just stores each byte; second channel registers not built
   assign marker_fall = marker_prev & ~monitor_tx_marker;
   always_comb begin
      rx_take = 1'b0;
      if (gen2 & monitor_control_reg[`IIL_MOC_RX_EN]) begin
         if (monitor_control_reg[`IIL_MOC_HS]) begin
            rx_take = marker_fall;
         end else begin
            rx_take = mon_byte_valid & ~in_packet;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         marker_prev <= 1'b1;
         in_packet   <= 1'b0;
      end else begin
         marker_prev <= monitor_tx_marker;
         if (mon_end) begin
            in_packet <= 1'b0;
         end else if (mon_byte_valid) begin
            in_packet <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mon_data <= 8'h00;
      end else if (rx_take | (~gen2 & mon_byte_valid)) begin
         mon_data <= mon_byte_in;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         monitor_state_reg <= 4'h0;
      end else begin
         monitor_state_reg <= (monitor_state_reg & ~{4{rd & hit(widx, `IIL_ADR_MOSTAT)}})
            | {gen2 & monitor_control_reg[`IIL_MOC_TX_EN] & mon_aborted,
               gen2 & monitor_control_reg[`IIL_MOC_TX_EN] & mon_acked,
               gen2 & monitor_control_reg[`IIL_MOC_RX_EN] & mon_end,
               rx_take};
      end
   end

   // handshake bit low while a stored byte waits for the host
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         monitor_rx_marker <= 1'b1;
      end else if (gen2 & monitor_control_reg[`IIL_MOC_HS] & marker_fall & monitor_control_reg[`IIL_MOC_RX_EN]) begin
         monitor_rx_marker <= 1'b0;
      end else if (rd & hit(widx, `IIL_ADR_MODATA)) begin
         monitor_rx_marker <= 1'b1;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// request line, open drain, moved only on data clock rising edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sdc_meta <= 1'b0;
         sdc_sync <= 1'b0;
         sdc_prev <= 1'b0;
      end else begin
         sdc_meta <= serial_data_clock;
         sdc_sync <= sdc_meta;
         sdc_prev <= sdc_sync;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_out  <= 1'b0;
         irq_oe_n <= 1'b1;
      end else begin
         irq_out <= 1'b0;
         if (sdc_sync & ~sdc_prev) begin
            // released once nothing unmasked is pending
            irq_oe_n <= ~req;
         end
      end
   end

endmodule
